// file: logic/pph_port.sv
// One handshake port: pin synchronisers, driver control and reply pulse timing.
`timescale 1ns/1ps
module pph_port
    import pph_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic              dir_in,
    input  wire logic              rd_strobe_in,
    input  wire logic              wr_strobe_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              peer_ready_n_in,
    input  wire logic              peer_reply_n_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_n_out,
    output logic                   port_ready_out,
    output logic                   port_reply_pulse_out,
    output logic      [DATA_W-1:0] rd_data_out,
    output logic                   peer_ready_out,
    output logic                   peer_reply_out,
    output logic                   busy_out
);

    typedef struct packed {
        logic [DATA_W-1:0] data_s1;
        logic [DATA_W-1:0] data_s2;
        logic              rdy_s1;
        logic              rdy_s2;
        logic              rply_s1;
        logic              rply_s2;
        pph_state_e        state;
        logic [CNT_W-1:0]  cnt;
        logic              ready;
        logic              reply;
        logic              oe_n;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] rdata;
        logic              busy;
    } pph_port_s;

    pph_port_s st_ff;
    pph_port_s nxt_st;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.data_s1 = data_in;
        nxt_st.data_s2 = st_ff.data_s1;
        nxt_st.rdy_s1  = ~peer_ready_n_in;
        nxt_st.rdy_s2  = st_ff.rdy_s1;
        nxt_st.rply_s1 = ~peer_reply_n_in;
        nxt_st.rply_s2 = st_ff.rply_s1;
        // The read buffer follows the lines so plain polling works without a handshake.
        nxt_st.rdata   = st_ff.data_s2;
        nxt_st.ready   = ~dir_in;
        // Ready and driver disable switch on the same edge, well inside the allowed delay.
        nxt_st.oe_n    = ~(dir_in & st_ff.rdy_s2);
        case (st_ff.state)
            PPH_IDLE: begin
                if (wr_strobe_in) begin
                    nxt_st.dout = wr_data_in;
                end
                if (wr_strobe_in && dir_in) begin
                    nxt_st.state = PPH_SETUP;
                    nxt_st.cnt   = CNT_RST;
                end else if (rd_strobe_in && !dir_in) begin
                    nxt_st.reply = 1'b1;
                    nxt_st.state = PPH_PULSE;
                    nxt_st.cnt   = CNT_RST;
                end
            end
            PPH_SETUP: begin
                // Only cycles with the drivers on count toward the data lead time.
                if (st_ff.oe_n) begin
                    nxt_st.cnt = CNT_RST;
                end else if (st_ff.cnt == SETUP_LAST) begin
                    nxt_st.reply = 1'b1;
                    nxt_st.cnt   = CNT_RST;
                    nxt_st.state = PPH_PULSE;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 8'h01;
                end
            end
            PPH_PULSE: begin
                if (st_ff.cnt == PULSE_LAST) begin
                    nxt_st.reply = 1'b0;
                    nxt_st.cnt   = CNT_RST;
                    nxt_st.state = PPH_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 8'h01;
                end
            end
            default: begin
                nxt_st.state = PPH_IDLE;
                nxt_st.reply = 1'b0;
                nxt_st.cnt   = CNT_RST;
            end
        endcase
        // Busy is its own flop so the status word carries no decode logic.
        nxt_st.busy = (nxt_st.state != PPH_IDLE);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '{data_s1: DATA_RST, data_s2: DATA_RST, rdy_s1: 1'b0, rdy_s2: 1'b0,
                       rply_s1: 1'b0, rply_s2: 1'b0, state: PPH_IDLE, cnt: CNT_RST,
                       ready: 1'b1, reply: 1'b0, oe_n: 1'b1, dout: DATA_RST, rdata: DATA_RST,
                       busy: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign data_out             = st_ff.dout;
    assign data_oe_n_out        = st_ff.oe_n;
    assign port_ready_out       = st_ff.ready;
    assign port_reply_pulse_out = st_ff.reply;
    assign rd_data_out          = st_ff.rdata;
    assign peer_ready_out       = st_ff.rdy_s2;
    assign peer_reply_out       = st_ff.rply_s2;
    assign busy_out             = st_ff.busy;

endmodule

// file: logic/pph_pkg.sv
// Shared constants for the parallel port handshake block.
package pph_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_PORTS      = 4;
    localparam int DATA_W         = 16;
    localparam int IRQ_W          = 16;
    localparam int IRQ_LOW_W      = 12;
    localparam int CNT_W          = 8;

    // ------------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------------
    localparam int IRQ_EN_BIT     = 9;
    localparam int PEER_READY_BIT = 15;
    localparam int PEER_REPLY_BIT = 7;
    localparam int BUSY_BIT       = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int T_DRV_OFF_NS   = 50;
    localparam int T_PULSE_MIN_NS = 410;
    localparam int T_PULSE_MAX_NS = 2000;
    localparam int T_SETUP_NS     = 300;

    // Least times round up to whole cycles.
    localparam int PULSE_CYC      = (T_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC      = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_MAX_CYC  = T_PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam int DRV_OFF_CYC    = T_DRV_OFF_NS / CLK_PERIOD_NS;

    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC - 1);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [IRQ_W-1:0]  IRQ_RST  = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;

    // ------------------------------------------------------------------
    // Port sequencer states, Gray coded along idle, setup, pulse
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PPH_IDLE  = 2'h0,
        PPH_SETUP = 2'h1,
        PPH_PULSE = 2'h3
    } pph_state_e;

endpackage

// file: logic/parallel_port_handshake.sv
// Top of the four-port parallel handshake block with its interrupt request capture.
//
// Contract
// - Each transfer moves one 16-bit word over sixteen three-state lines.
// - For input, the device raises its ready output to invite a word.
// - For input, after the buffer read the device sends its reply pulse.
// - For output, the device drives the word, then sends its reply pulse.
// - Device drivers switch off within 50 ns of ready being asserted.
// - The reply pulse lasts between 410 ns and 2000 ns.
// - Output data is driven at least 300 ns before the reply pulse.
// - Accept 16 interrupt requests from port A lines or replies plus A lines.
// - Requests are ignored until bit 9 of the first port control is set.
// - Without input handshake, data is read by polling in input direction.
// - Turn-around steps are needed only when a port changes direction.
// - Ready output is asserted whenever the direction bit selects input.
// - Reading the buffer with direction cleared starts a reply pulse.
// - Writing the buffer with direction set starts a reply pulse.
// - Drivers enable only with peer ready and output direction; peer ready shows at bit 15.
`timescale 1ns/1ps
module parallel_port_handshake
    import pph_pkg::*;
(
    input  wire logic                        clock_in,
    input  wire logic                        rst_n_in,
    input  wire logic [NUM_PORTS-1:0]        dir_in,
    input  wire logic [NUM_PORTS-1:0]        rd_strobe_in,
    input  wire logic [NUM_PORTS-1:0]        wr_strobe_in,
    input  wire logic [NUM_PORTS*DATA_W-1:0] wr_data_in,
    input  wire logic [NUM_PORTS*DATA_W-1:0] data_in,
    input  wire logic [NUM_PORTS-1:0]        peer_ready_n_in,
    input  wire logic [NUM_PORTS-1:0]        peer_reply_n_in,
    input  wire logic [DATA_W-1:0]           first_port_control_status_in,
    input  wire logic                        irq_source_sel_in,
    input  wire logic [IRQ_W-1:0]            irq_clear_in,
    output logic      [NUM_PORTS*DATA_W-1:0] data_out,
    output logic      [NUM_PORTS-1:0]        data_oe_n_out,
    output logic      [NUM_PORTS-1:0]        port_ready_out,
    output logic      [NUM_PORTS-1:0]        port_reply_pulse_out,
    output logic      [NUM_PORTS*DATA_W-1:0] rd_data_out,
    output logic      [NUM_PORTS*DATA_W-1:0] port_status_out,
    output logic      [IRQ_W-1:0]            irq_pending_out
);

    logic [NUM_PORTS-1:0] peer_ready;
    logic [NUM_PORTS-1:0] peer_reply;
    logic [NUM_PORTS-1:0] busy;

    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
            pph_port u_port (
                .clock_in             (clock_in),
                .rst_n_in             (rst_n_in),
                .dir_in               (dir_in[gi]),
                .rd_strobe_in         (rd_strobe_in[gi]),
                .wr_strobe_in         (wr_strobe_in[gi]),
                .wr_data_in           (wr_data_in[gi*DATA_W +: DATA_W]),
                .data_in              (data_in[gi*DATA_W +: DATA_W]),
                .peer_ready_n_in      (peer_ready_n_in[gi]),
                .peer_reply_n_in      (peer_reply_n_in[gi]),
                .data_out             (data_out[gi*DATA_W +: DATA_W]),
                .data_oe_n_out        (data_oe_n_out[gi]),
                .port_ready_out       (port_ready_out[gi]),
                .port_reply_pulse_out (port_reply_pulse_out[gi]),
                .rd_data_out          (rd_data_out[gi*DATA_W +: DATA_W]),
                .peer_ready_out       (peer_ready[gi]),
                .peer_reply_out       (peer_reply[gi]),
                .busy_out             (busy[gi])
            );
            // Status fields are flop bits placed into a word, no logic in between.
            assign port_status_out[gi*DATA_W +: DATA_W] = {peer_ready[gi],
                                                           7'h00,
                                                           peer_reply[gi],
                                                           6'h00,
                                                           busy[gi]};
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt request capture
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [IRQ_W-1:0] pending;
    } pph_top_s;

    pph_top_s st_ff;
    pph_top_s nxt_st;

    logic [IRQ_W-1:0] irq_src;

    always_comb begin
        // Port A read buffer holds the synchronised line levels.
        if (irq_source_sel_in) begin
            irq_src = {peer_reply, rd_data_out[IRQ_LOW_W-1:0]};
        end else begin
            irq_src = rd_data_out[DATA_W-1:0];
        end
        nxt_st = st_ff;
        // A request in the same cycle as its clear stays pending.
        nxt_st.pending = (st_ff.pending & ~irq_clear_in)
                       | (irq_src & {IRQ_W{first_port_control_status_in[IRQ_EN_BIT]}});
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '{pending: IRQ_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign irq_pending_out = st_ff.pending;

endmodule

// file: bench/pph_monitor.sv
// Concurrent checks on port 0 and on the interrupt capture of the parallel port handshake block.
`timescale 1ns/1ps
module pph_monitor
    import pph_pkg::*;
(
    input wire logic                        clock_in,
    input wire logic                        rst_n_in,
    input wire logic [NUM_PORTS-1:0]        dir_in,
    input wire logic [NUM_PORTS-1:0]        rd_strobe_in,
    input wire logic [NUM_PORTS-1:0]        wr_strobe_in,
    input wire logic [NUM_PORTS*DATA_W-1:0] wr_data_in,
    input wire logic [NUM_PORTS-1:0]        peer_ready_n_in,
    input wire logic [DATA_W-1:0]           first_port_control_status_in,
    input wire logic [NUM_PORTS*DATA_W-1:0] data_out,
    input wire logic [NUM_PORTS-1:0]        data_oe_n_out,
    input wire logic [NUM_PORTS-1:0]        port_ready_out,
    input wire logic [NUM_PORTS-1:0]        port_reply_pulse_out,
    input wire logic [NUM_PORTS*DATA_W-1:0] port_status_out,
    input wire logic [IRQ_W-1:0]            irq_pending_out
);
    // Port 0 stands for all four, since the ports are identical copies.
    logic [7:0] hi_cnt_ff;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_cnt_ff <= 8'h00;
        end else begin
            hi_cnt_ff <= port_reply_pulse_out[0] ? hi_cnt_ff + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    property p_ready; !dir_in[0] |=> port_ready_out[0] && data_oe_n_out[0]; endproperty
    a_ready: assert property (p_ready) else $error("ready or driver off wrong in input");
    property p_oe; !data_oe_n_out[0] |-> $past(dir_in[0]) && !$past(peer_ready_n_in[0], 3); endproperty
    a_oe: assert property (p_oe) else $error("drivers on without output and peer ready");
    property p_read; rd_strobe_in[0] && !dir_in[0] && !port_status_out[BUSY_BIT] |=> port_reply_pulse_out[0]; endproperty
    a_read: assert property (p_read) else $error("no reply pulse after read");
    property p_write;
        wr_strobe_in[0] && dir_in[0] && !port_status_out[BUSY_BIT] && !data_oe_n_out[0]
            |-> ##[30:32] $rose(port_reply_pulse_out[0]);
    endproperty
    a_write: assert property (p_write) else $error("no reply pulse after write");
    property p_setup;
        $rose(port_reply_pulse_out[0]) && !port_ready_out[0]
            |-> !$past(data_oe_n_out[0], 30) && $past(data_out[15:0], 30) == data_out[15:0];
    endproperty
    a_setup: assert property (p_setup) else $error("data not held before reply pulse");
    property p_width; $fell(port_reply_pulse_out[0]) |-> hi_cnt_ff == 8'h29; endproperty
    a_width: assert property (p_width) else $error("reply pulse width wrong");
    property p_wmax; port_reply_pulse_out[0] |-> hi_cnt_ff < 8'h29; endproperty
    a_wmax: assert property (p_wmax) else $error("reply pulse too long");
    property p_data; wr_strobe_in[0] && !port_status_out[BUSY_BIT] |=> data_out[15:0] == $past(wr_data_in[15:0]); endproperty
    a_data: assert property (p_data) else $error("written word not driven");
    property p_irq; !first_port_control_status_in[IRQ_EN_BIT] && irq_pending_out == 16'h0000 |=> irq_pending_out == 16'h0000;
    endproperty
    a_irq: assert property (p_irq) else $error("request taken while disabled");
endmodule
bind parallel_port_handshake pph_monitor pph_monitor_inst (.clock_in, .rst_n_in, .dir_in, .rd_strobe_in,
    .wr_strobe_in, .wr_data_in, .peer_ready_n_in, .first_port_control_status_in, .data_out, .data_oe_n_out,
    .port_ready_out, .port_reply_pulse_out, .port_status_out, .irq_pending_out);

// file: bench/pph_peer_model.sv
// Behavioural user device on the far end of one port cable.
`timescale 1ns/1ps
module pph_peer_model
    import pph_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              ready_in,
    input  wire logic              pulse_in,
    input  wire logic              oe_n_in,
    input  wire logic [DATA_W-1:0] dev_data_in,
    input  wire logic              send_in,
    input  wire logic              want_in,
    input  wire logic [DATA_W-1:0] word_in,
    input  wire logic [7:0]        dly_in,
    output logic      [DATA_W-1:0] line_out,
    output logic                   ready_n_out,
    output logic                   reply_n_out = 1'b1,
    output logic      [DATA_W-1:0] got_out = '0,
    output logic                   got_stb_out = 1'b0
);
    logic              drv_ff = 1'b0;
    logic [DATA_W-1:0] last_ff = '0;
    // A line nobody drives shows the inverse of its last level, so stale data cannot pass for fresh.
    assign line_out    = !oe_n_in ? dev_data_in : (drv_ff ? last_ff : ~last_ff);
    assign ready_n_out = !want_in;
    always @(posedge clock_in) begin
        if (send_in && ready_in && !drv_ff) begin
            repeat (5 + dly_in) @(posedge clock_in);
            drv_ff <= 1'b1;
            last_ff <= word_in;
            repeat (3) @(posedge clock_in);
            reply_n_out <= 1'b0;
            @(posedge clock_in iff pulse_in);
            drv_ff <= 1'b0;
            reply_n_out <= 1'b1;
        end else if (pulse_in && !ready_in) begin
            got_out <= line_out;
            last_ff <= line_out;
            got_stb_out <= 1'b1;
            reply_n_out <= 1'b0;
            @(posedge clock_in);
            got_stb_out <= 1'b0;
            repeat (27 + dly_in) @(posedge clock_in);
            reply_n_out <= 1'b1;
            @(posedge clock_in iff !pulse_in);
        end
    end
endmodule

// file: bench/parallel_port_handshake_test.sv
// Self-checking bench for the parallel port handshake block with four peer models.
`timescale 1ns/1ps
module parallel_port_handshake_test
    import pph_pkg::*;
;
    logic                        clock_in = 1'b0;
    logic                        rst_n_in, irq_source_sel_in;
    logic [NUM_PORTS-1:0]        dir_in, rd_strobe_in, wr_strobe_in, send, want, prev = '0;
    logic [NUM_PORTS*DATA_W-1:0] wr_data_in;
    logic [DATA_W-1:0]           first_port_control_status_in, irq_clear_in, w, line0;
    logic [DATA_W-1:0]           word [NUM_PORTS];
    logic [7:0]                  dly [NUM_PORTS];
    logic [DATA_W-1:0]           expq [$];
    wire  [NUM_PORTS*DATA_W-1:0] data_in, data_out, rd_data_out, port_status_out;
    wire  [NUM_PORTS-1:0]        peer_ready_n_in, peer_reply_n_in, data_oe_n_out, port_ready_out;
    wire  [NUM_PORTS-1:0]        port_reply_pulse_out, got_stb;
    wire  [DATA_W-1:0]           irq_pending_out;
    wire  [DATA_W-1:0]           got [NUM_PORTS];
    int                          seed = 74978, miscompares = 0, checks = 0, k;
    always #5 clock_in = ~clock_in;
    parallel_port_handshake parallel_port_handshake_inst (.clock_in, .rst_n_in, .dir_in, .rd_strobe_in,
        .wr_strobe_in, .wr_data_in, .data_in, .peer_ready_n_in, .peer_reply_n_in, .first_port_control_status_in,
        .irq_source_sel_in, .irq_clear_in, .data_out, .data_oe_n_out, .port_ready_out, .port_reply_pulse_out,
        .rd_data_out, .port_status_out, .irq_pending_out);
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_peer
        pph_peer_model pph_peer_model_inst (.clock_in, .ready_in(port_ready_out[g]),
            .pulse_in(port_reply_pulse_out[g]), .oe_n_in(data_oe_n_out[g]), .dev_data_in(data_out[DATA_W*g +: DATA_W]),
            .send_in(send[g]), .want_in(want[g]), .word_in(word[g]), .dly_in(dly[g]),
            .line_out(data_in[DATA_W*g +: DATA_W]), .ready_n_out(peer_ready_n_in[g]),
            .reply_n_out(peer_reply_n_in[g]), .got_out(got[g]), .got_stb_out(got_stb[g]));
    end
    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] seen);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic strobe(input int p, input logic wr, input logic [DATA_W-1:0] v);
        wr_data_in[DATA_W*p +: DATA_W] = v;
        wr_strobe_in[p] = wr;
        rd_strobe_in[p] = !wr;
        @(negedge clock_in);
        wr_strobe_in = '0;
        rd_strobe_in = '0;
        @(negedge clock_in);
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(negedge clock_in) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_reply_pulse_out[p] && !prev[p] && port_ready_out[p])
                chk("input word", expq.pop_front(), rd_data_out[DATA_W*p +: DATA_W]);
            if (got_stb[p] === 1'b1)
                chk("output word", expq.pop_front(), got[p]);
        end
        prev <= port_reply_pulse_out;
    end
    // The whole run needs some 10 us; a hang is cut off well after that.
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
    initial begin
        {dir_in, rd_strobe_in, wr_strobe_in, send, want, wr_data_in} = '0;
        {first_port_control_status_in, irq_clear_in, irq_source_sel_in} = '0;
        word = '{default: '0};
        dly = '{default: '0};
        rst_n_in = 1'b0;
        repeat (10) @(negedge clock_in);
        rst_n_in = 1'b1;
        chk("ready after reset", 16'h000F, {12'h000, port_ready_out});
        chk("oe_n after reset", 16'h000F, {12'h000, data_oe_n_out});
        for (int p = 0; p < NUM_PORTS; p++) begin
            word[p] = 16'($random(seed));
            dly[p] = 8'($random(seed)) & 8'h1F;
            send[p] = 1'b1;
            for (k = 0; !port_status_out[DATA_W*p+PEER_REPLY_BIT] && k < 400; k++) @(negedge clock_in);
            chk("peer reply wait", 16'h0000, 16'(k == 400));
            expq.push_back(word[p]);
            strobe(p, 1'b0, '0);
            send[p] = 1'b0;
            for (k = 0; port_status_out[DATA_W*p+BUSY_BIT] && k < 400; k++) @(negedge clock_in);
            chk("input busy wait", 16'h0000, 16'(k == 400));
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            dir_in[p] = 1'b1;
            want[p] = 1'b1;
            for (k = 0; data_oe_n_out[p] && k < 400; k++) @(negedge clock_in);
            chk("driver enable wait", 16'h0000, 16'(k == 400));
            chk("status in output", 16'h8000, port_status_out[DATA_W*p +: DATA_W]);
            chk("ready in output", 16'h0000, 16'(port_ready_out[p]));
            repeat (2) begin
                w = 16'($random(seed));
                expq.push_back(w);
                strobe(p, 1'b1, w);
                strobe(p, 1'b1, ~w);
                chk("data_out", w, data_out[DATA_W*p +: DATA_W]);
                for (k = 0; port_status_out[DATA_W*p+BUSY_BIT] && k < 400; k++) @(negedge clock_in);
                chk("output busy wait", 16'h0000, 16'(k == 400));
            end
            if (p == 0)
                line0 = ~w;
        end
        dir_in = '0;
        want = '0;
        repeat (60) @(negedge clock_in);
        chk("pending disabled", 16'h0000, irq_pending_out);
        first_port_control_status_in[IRQ_EN_BIT] = 1'b1;
        @(negedge clock_in);
        chk("pending lines", line0, irq_pending_out);
        first_port_control_status_in = '0;
        irq_clear_in = 16'hFFFF;
        irq_source_sel_in = 1'b1;
        @(negedge clock_in);
        irq_clear_in = '0;
        first_port_control_status_in[IRQ_EN_BIT] = 1'b1;
        @(negedge clock_in);
        chk("pending replies", {4'h0, line0[11:0]}, irq_pending_out);
        summarize();
    end
endmodule
